// ### compressor_gain_control.sv
`timescale 1ns/1ns
module sample_fifo #(
    parameter int W = 20,
    parameter int D = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Fill side
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    // Drain side
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ff;
    logic [AW:0]  rd_ff;
    wire full  = (wr_ff[AW] != rd_ff[AW]) &&
                 (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    wire push  = in_valid_in && !full;
    wire pop   = out_ready_in && !empty;
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem[rd_ff[AW-1:0]];
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= wr_ff + (AW+1)'(push);
            rd_ff <= rd_ff + (AW+1)'(pop);
        end
    end
endmodule : sample_fifo

module rate_tick (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        tick_in,
    input  wire logic        run_in,
    input  wire logic [19:0] period_in,
    output logic             pulse_out
);
    logic [19:0] cnt_ff;
    wire last = (cnt_ff >= period_in - 20'h0_0001);
    assign pulse_out = run_in && tick_in && last;
    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            cnt_ff <= '0;
        end else if (tick_in) begin
            cnt_ff <= last ? 20'h0_0000 : cnt_ff + 20'h0_0001;
        end
    end
endmodule : rate_tick

module compressor_gain_control #(
    parameter int HOLD_LONG  = cgc_pkg::HOLD_LONG_TICKS,
    parameter int HOLD_SHORT = cgc_pkg::HOLD_SHORT_TICKS
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Configuration
    input  wire logic [7:0]  compressor_control_reg_in,
    input  wire logic [7:0]  fast_rate_select_reg_in,
    input  wire logic [7:0]  slow_rate_format_reg_in,
    input  wire logic [7:0]  gain_target_reg_in,
    input  wire logic [1:0]  filter_format_reg_in,
    // Level comparators
    input  wire logic        upper_level_threshold_in,
    input  wire logic        below_lower_in,
    // Gain
    output logic [cgc_pkg::GAIN_W-1:0] gain_code_out,
    output logic [7:0]       gain_read_out,
    // Converter samples
    input  wire logic        mod_bit_in,
    output logic [15:0]      sample_out,
    output logic             sample_valid_out,
    // DAC words
    input  wire logic [cgc_pkg::DAC_W-1:0] dac_word_in,
    input  wire logic        dac_valid_in,
    output logic             dac_ready_out,
    output logic [3:0]       dac_level_out
);
    import cgc_pkg::*;

    // System tick generation
    logic [13:0] acc_ff;
    wire [13:0] acc_sum = acc_ff + ACC_STEP;
    wire tick = (acc_sum >= ACC_MOD);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= tick ? acc_sum - ACC_MOD : acc_sum;
        end
    end

    logic [1:0] up_sync_ff;
    logic [1:0] lo_sync_ff;
    logic [1:0] bit_sync_ff;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            up_sync_ff  <= '0;
            lo_sync_ff  <= '0;
            bit_sync_ff <= '0;
        end else begin
            up_sync_ff  <= {up_sync_ff[0], upper_level_threshold_in};
            lo_sync_ff  <= {lo_sync_ff[0], below_lower_in};
            bit_sync_ff <= {bit_sync_ff[0], mod_bit_in};
        end
    end
    wire upper_s = up_sync_ff[1];
    wire below_s = lo_sync_ff[1];

    wire [1:0] mode = compressor_control_reg_in[MODE_LSB+1:MODE_LSB];
    wire is_dual  = (mode == MODE_DUAL);
    wire is_auto  = (mode == MODE_DUAL) || (mode == MODE_AUTO1);
    wire is_step  = (mode == MODE_STEP);
    wire [GAIN_W-1:0] tgt = gain_target_reg_in[GAIN_W-1:0];

    logic [GAIN_W-1:0] fast_ff;
    logic [GAIN_W-1:0] slow_ff;
    logic [GAIN_W-1:0] gain_ff;
    logic [16:0]       hold_ff;

    wire [16:0] hold_lim = compressor_control_reg_in[HOLD_SEL_BIT] ?
                           17'(HOLD_SHORT) : 17'(HOLD_LONG);
    wire hold_done = (hold_ff >= hold_lim);
    always_ff @(posedge clk_in) begin
        if (rst_in || !below_s) begin
            hold_ff <= '0;
        end else if (tick && !hold_done) begin
            hold_ff <= hold_ff + 17'h0_0001;
        end
    end

    // rate periods; code 0 is the 80 KdB/s step
    wire [19:0] fa_per = RATE_BASE_TICKS << fast_rate_select_reg_in[3:0];
    wire [19:0] fr_per = RATE_BASE_TICKS << fast_rate_select_reg_in[7:4];
    wire [19:0] sa_per = RATE_BASE_TICKS << slow_rate_format_reg_in[3:0];
    wire [19:0] sr_per = RATE_BASE_TICKS << slow_rate_format_reg_in[7:4];
    wire fa_run = is_auto ? upper_s : (is_step && gain_ff > tgt);
    wire fr_run = is_auto ? (hold_done && !upper_s)
                          : (is_step && gain_ff < tgt);
    wire sa_run = is_dual && (slow_ff > fast_ff);
    wire sr_run = is_dual && (slow_ff < fast_ff);
    wire fa_tick;
    wire fr_tick;
    wire sa_tick;
    wire sr_tick;
    rate_tick u_fa (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick),
        .run_in(fa_run), .period_in(fa_per), .pulse_out(fa_tick));
    rate_tick u_fr (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick),
        .run_in(fr_run), .period_in(fr_per), .pulse_out(fr_tick));
    rate_tick u_sa (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick),
        .run_in(sa_run), .period_in(sa_per), .pulse_out(sa_tick));
    rate_tick u_sr (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick),
        .run_in(sr_run), .period_in(sr_per), .pulse_out(sr_tick));

    logic [GAIN_W-1:0] nxt_fast;
    always_comb begin
        nxt_fast = fast_ff;
        if (!is_auto) begin
            nxt_fast = gain_ff;
        end else if (fast_ff > tgt) begin
            nxt_fast = tgt;
        end else if (fa_tick && fast_ff != '0) begin
            nxt_fast = fast_ff - 7'h01;
        end else if (fr_tick && fast_ff < tgt) begin
            nxt_fast = fast_ff + 7'h01;
        end
    end

    logic [GAIN_W-1:0] nxt_slow;
    always_comb begin
        nxt_slow = slow_ff;
        if (!is_dual) begin
            nxt_slow = fast_ff;
        end else if (sa_tick) begin
            nxt_slow = slow_ff - 7'h01;
        end else if (sr_tick) begin
            nxt_slow = slow_ff + 7'h01;
        end
    end

    logic [GAIN_W-1:0] nxt_gain;
    always_comb begin
        case (mode)
            MODE_DUAL:  nxt_gain = (fast_ff < slow_ff) ? fast_ff : slow_ff;
            MODE_AUTO1: nxt_gain = fast_ff;
            MODE_STEP: begin
                nxt_gain = gain_ff;
                if (fa_tick) begin
                    nxt_gain = gain_ff - 7'h01;
                end else if (fr_tick) begin
                    nxt_gain = gain_ff + 7'h01;
                end
            end
            MODE_IMM:   nxt_gain = tgt;
            default:    nxt_gain = gain_ff;
        endcase
    end

    wire [7:0] nxt_read = gain_target_reg_in[READ_SEL_BIT] ?
                          {1'b0, gain_ff} : gain_target_reg_in;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fast_ff       <= GAIN_RESET;
            slow_ff       <= GAIN_RESET;
            gain_ff       <= GAIN_RESET;
            gain_read_out <= '0;
        end else begin
            fast_ff       <= nxt_fast;
            slow_ff       <= nxt_slow;
            gain_ff       <= nxt_gain;
            gain_read_out <= nxt_read;
        end
    end
    assign gain_code_out = gain_ff;

    logic [DEC_OSR-1:0] dec_sr_ff;
    logic [6:0]         dec_sum_ff;
    logic [5:0]         out_cnt_ff;
    wire out_tick = tick && (out_cnt_ff == OUT_TICKS - 6'h01);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dec_sr_ff  <= '0;
            dec_sum_ff <= '0;
            out_cnt_ff <= '0;
        end else if (tick) begin
            dec_sr_ff  <= {dec_sr_ff[DEC_OSR-2:0], bit_sync_ff[1]};
            dec_sum_ff <= dec_sum_ff + 7'(bit_sync_ff[1])
                          - 7'(dec_sr_ff[DEC_OSR-1]);
            out_cnt_ff <= out_tick ? 6'h00 : out_cnt_ff + 6'h01;
        end
    end
    wire signed [17:0] dec_wide =
        $signed({1'b0, dec_sum_ff, 10'h000}) - 18'sh0_8000;
    wire signed [15:0] dec_x = (dec_wide > 18'sh0_7FFF) ?
                               16'sh7FFF : dec_wide[15:0];

    // first-order high-pass; reset code is 50 Hz
    logic signed [15:0] hp_x_ff;
    logic signed [17:0] hp_y_ff;
    wire bypass = filter_format_reg_in[1];
    wire signed [17:0] hp_leak = (filter_format_reg_in == FILT_100) ?
        (hp_y_ff >>> HPF_SHIFT_100) : (hp_y_ff >>> HPF_SHIFT_50);
    wire signed [17:0] hp_y = 18'(dec_x) - 18'(hp_x_ff) + hp_y_ff - hp_leak;
    wire signed [15:0] hp_sat =
        (hp_y > 18'sh0_7FFF)  ? 16'sh7FFF :
        (hp_y < -18'sh0_8000) ? -16'sh8000 : hp_y[15:0];
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hp_x_ff          <= '0;
            hp_y_ff          <= '0;
            sample_out       <= '0;
            sample_valid_out <= 1'b0;
        end else begin
            sample_valid_out <= out_tick;
            if (out_tick) begin
                hp_x_ff    <= dec_x;
                hp_y_ff    <= 18'(hp_sat);
                sample_out <= bypass ? dec_x : hp_sat;
            end
        end
    end

    // word fetch at 40 kHz, modulator at 640 kHz
    wire [DAC_W-1:0] fifo_word;
    wire             fifo_valid;
    logic [4:0] word_cnt_ff;
    logic [1:0] mod_cnt_ff;
    wire word_tick = tick && (word_cnt_ff == 5'(DAC_OSR - 1));
    wire mod_tick  = tick && (mod_cnt_ff == MOD_TICKS - 2'h1);
    wire fifo_pop  = word_tick && fifo_valid;
    sample_fifo #(.W(DAC_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .in_data_in   (dac_word_in),
        .in_valid_in  (dac_valid_in),
        .in_ready_out (dac_ready_out),
        .out_data_out (fifo_word),
        .out_valid_out(fifo_valid),
        .out_ready_in (fifo_pop)
    );
    logic signed [DAC_W-1:0] word_ff;
    logic [15:0]             err_ff;
    wire signed [20:0] mod_sum = 21'(word_ff) + $signed({5'h00, err_ff});
    wire mod_ovf = (mod_sum[20] != mod_sum[19]);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            word_cnt_ff   <= '0;
            mod_cnt_ff    <= '0;
            word_ff       <= '0;
            err_ff        <= '0;
            dac_level_out <= '0;
        end else begin
            if (tick) begin
                word_cnt_ff <= word_tick ? 5'h00 : word_cnt_ff + 5'h01;
                mod_cnt_ff  <= mod_tick ? 2'h0 : mod_cnt_ff + 2'h1;
            end
            if (fifo_pop) begin
                word_ff <= fifo_word;
            end
            if (mod_tick) begin
                dac_level_out <= mod_ovf ? 4'h7 : mod_sum[19:16];
                err_ff        <= mod_ovf ? err_ff : mod_sum[15:0];
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_imm;
        (mode == MODE_IMM) |=> (gain_code_out == $past(tgt));
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate gain not applied");
    property p_step;
        (is_step && $past(is_step)) |->
            (gain_ff == $past(gain_ff) || gain_ff == $past(gain_ff) + 7'h01
             || gain_ff == $past(gain_ff) - 7'h01);
    endproperty
    a_step: assert property (p_step)
        else $error("fixed gain skipped a step");
    property p_cap;
        (is_auto && $past(is_auto)) |-> (fast_ff <= $past(tgt));
    endproperty
    a_cap: assert property (p_cap)
        else $error("fast counter above target");
    property p_min;
        is_dual |=> (gain_ff == (($past(fast_ff) < $past(slow_ff)) ?
                                 $past(fast_ff) : $past(slow_ff)));
    endproperty
    a_min: assert property (p_min)
        else $error("dual gain not the lesser count");
    property p_single;
        (mode == MODE_AUTO1) |=> (gain_ff == $past(fast_ff));
    endproperty
    a_single: assert property (p_single)
        else $error("single gain not the fast count");
    property p_hold;
        (is_auto && $past(is_auto) && fast_ff > $past(fast_ff)
         && $past(fast_ff) <= $past(tgt)) |-> $past(hold_done);
    endproperty
    a_hold: assert property (p_hold)
        else $error("gain rose before hold elapsed");
    property p_attack;
        (is_auto && fa_tick && fast_ff != '0 && fast_ff <= tgt) |=>
            (fast_ff == $past(fast_ff) - 7'h01);
    endproperty
    a_attack: assert property (p_attack)
        else $error("attack did not lower fast count");
    property p_read;
        gain_target_reg_in[READ_SEL_BIT] |=>
            (gain_read_out == {1'b0, $past(gain_ff)});
    endproperty
    a_read: assert property (p_read)
        else $error("live gain readback wrong");
    property p_sync;
        ##2 (upper_s == $past(upper_level_threshold_in, 2));
    endproperty
    a_sync: assert property (p_sync)
        else $error("comparator sync depth wrong");
    property p_pulse;
        sample_valid_out |=> !sample_valid_out;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("sample strobe longer than a cycle");
endmodule : compressor_gain_control

// ### cgc_pkg.sv
package cgc_pkg;
    localparam int CLK_HZ  = 100_000_000;
    localparam int TICK_HZ = 1_280_000;
    localparam logic [13:0] ACC_STEP = 14'(TICK_HZ / 10_000);
    localparam logic [13:0] ACC_MOD  = 14'(CLK_HZ / 10_000);
    localparam int MODE_LSB     = 2;
    localparam int HOLD_SEL_BIT = 4;
    localparam int READ_SEL_BIT = 7;
    typedef enum logic [1:0] {
        MODE_DUAL  = 2'b00,
        MODE_AUTO1 = 2'b01,
        MODE_STEP  = 2'b10,
        MODE_IMM   = 2'b11
    } gain_mode_t;
    localparam int HOLD_LONG_MS  = 50;
    localparam int HOLD_SHORT_MS = 25;
    localparam int HOLD_LONG_TICKS  = HOLD_LONG_MS * (TICK_HZ / 1000);
    localparam int HOLD_SHORT_TICKS = HOLD_SHORT_MS * (TICK_HZ / 1000);
    localparam int SLEW_KDB_S = 80;
    localparam int STEP_MDB   = 500;
    localparam logic [19:0] RATE_BASE_TICKS =
        20'(TICK_HZ * STEP_MDB / (SLEW_KDB_S * 1_000_000));
    localparam int GAIN_W = 7;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 7'h00;
    localparam int DEC_OSR  = 64;
    localparam int OUT_HZ   = 40_000;
    localparam logic [5:0] OUT_TICKS = 6'(TICK_HZ / OUT_HZ);
    localparam int DAC_OSR  = 32;
    localparam int MOD_HZ   = 640_000;
    localparam logic [1:0] MOD_TICKS = 2'(TICK_HZ / MOD_HZ);
    localparam logic [1:0] FILT_50     = 2'h0;
    localparam logic [1:0] FILT_100    = 2'h1;
    localparam int HPF_SHIFT_50  = 7;
    localparam int HPF_SHIFT_100 = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int DAC_W      = 20;
endpackage : cgc_pkg

// ### level_amp_model.sv
`timescale 1ns/1ns
module level_amp_model #(
    parameter int UPPER_LVL  = 80,
    parameter int HYST_STEPS = 6
) (
    // Gain from the level logic
    input  wire logic [cgc_pkg::GAIN_W-1:0] gain_code_in,
    // Commanded input level and converter polarity
    input  wire logic [7:0]                 level_in,
    input  wire logic                       dc_in,
    // Comparators and converter stream
    output logic                            upper_level_threshold_out,
    output logic                            below_lower_out,
    output logic                            mod_bit_out
);
    import cgc_pkg::*;
    // Output level in 0.5 dB steps: input level plus applied gain
    logic [8:0] out_lvl;
    assign out_lvl = {1'b0, level_in} + {2'b00, gain_code_in};
    assign upper_level_threshold_out = (out_lvl > 9'(UPPER_LVL));
    assign below_lower_out = (out_lvl < 9'(UPPER_LVL - HYST_STEPS));
    // Full-scale stream of the commanded polarity
    assign mod_bit_out = dc_in;
endmodule : level_amp_model

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    import cgc_pkg::*;
    logic              clk_in;
    logic              rst_in;
    logic [7:0]        ctrl, fsel, ssel, tgt, level, rd;
    logic [1:0]        filt;
    logic              dc, upper, below, mbit, sv, dvalid, dready;
    logic [GAIN_W-1:0] gain, pgain;
    logic [15:0]       smp;
    logic [DAC_W-1:0]  dword;
    logic [3:0]        dlev;
    logic              watch = 1'b0;
    logic [GAIN_W-1:0] q_gain[$];
    logic [15:0]       q_smp[$];
    int                num_errors = 0;
    int                total_checks = 0;
    int                cyc = 0;
    int                last = 0;
    int                nsmp = 0;

    compressor_gain_control #(.HOLD_LONG(40), .HOLD_SHORT(20))
        compressor_gain_control_inst (
        .clk_in(clk_in), .rst_in(rst_in),
        .compressor_control_reg_in(ctrl), .fast_rate_select_reg_in(fsel),
        .slow_rate_format_reg_in(ssel), .gain_target_reg_in(tgt),
        .filter_format_reg_in(filt), .upper_level_threshold_in(upper),
        .below_lower_in(below), .gain_code_out(gain), .gain_read_out(rd),
        .mod_bit_in(mbit), .sample_out(smp), .sample_valid_out(sv),
        .dac_word_in(dword), .dac_valid_in(dvalid),
        .dac_ready_out(dready), .dac_level_out(dlev));

    level_amp_model level_amp_model_inst (
        .gain_code_in(gain), .level_in(level), .dc_in(dc),
        .upper_level_threshold_out(upper), .below_lower_out(below),
        .mod_bit_out(mbit));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check_gain(input string n, input logic [7:0] e,
                              input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask : check_gain

    task automatic check_sample(input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR sample expected %0h seen %0h", e, g);
        end
    endtask : check_sample

    task automatic check_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0b seen %0b", n, e, g);
        end
    endtask : check_bit

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cycles

    task automatic wait_gain(input logic [GAIN_W-1:0] e, input int lim,
                             output int k);
        k = 0;
        while (gain !== e && k < lim) begin
            @(negedge clk_in);
            k++;
        end
        check_gain("gain_settle", {1'b0, e}, {1'b0, gain});
    endtask : wait_gain

    task automatic wait_samples(input int n);
        int k;
        int stop;
        k = 0;
        stop = nsmp + n;
        while (nsmp < stop && k < n * 3000) begin
            @(negedge clk_in);
            k++;
        end
    endtask : wait_samples

    // Scoreboard: each observed result takes the oldest expectation
    // Looks at the falling edge, once the outputs have settled
    always @(negedge clk_in) begin
        cyc = cyc + 1;
        if (watch && gain !== pgain) begin
            if (q_gain.size() > 0)
                check_gain("gain_step", {1'b0, q_gain.pop_front()},
                           {1'b0, gain});
            else
                check_gain("gain_unexpected", {1'b0, pgain},
                           {1'b0, gain});
        end
        pgain = gain;
        if (sv === 1'b1) begin
            if (nsmp > 0)
                check_bit("sample_period", 1'b1,
                          (cyc - last) inside {[2499:2501]});
            last = cyc;
            nsmp = nsmp + 1;
            if (q_smp.size() > 0)
                check_sample(q_smp.pop_front(), smp);
        end
    end

    task automatic gain_tests;
        logic [6:0] t;
        int         k;
        ctrl = 8'h0C;
        watch = 1'b1;
        for (int i = 0; i < 6; i++) begin
            t = 7'($urandom_range(127));
            if (t == gain) t = t ^ 7'h01;
            q_gain.push_back(t);
            tgt = {1'b0, t};
            cycles(2);
            check_gain("gain_imm", {1'b0, t}, {1'b0, gain});
            cycles(1);
            check_gain("read_stored", {1'b0, t}, rd);
            tgt = {1'b1, t};
            cycles(3);
            check_gain("read_live", {1'b0, t}, rd);
        end
        if (gain !== 7'h40) q_gain.push_back(7'h40);
        tgt = 8'h40;
        cycles(3);
        ctrl = 8'h08;
        // Release select 1 doubles the step period to 16 ticks
        fsel = 8'h10;
        for (int i = 1; i <= 3; i++) q_gain.push_back(7'(8'h40 + i));
        tgt = 8'h43;
        wait_gain(7'h43, 5000, k);
        check_bit("step_up_time", 1'b1, k inside {[3600:3800]});
        for (int i = 2; i >= 0; i--) q_gain.push_back(7'(8'h40 + i));
        tgt = 8'h40;
        wait_gain(7'h40, 3000, k);
        check_bit("step_dn_time", 1'b1, k inside {[1240:1900]});
        fsel = 8'h00;
        cycles(2);
        check_bit("gain_queue_empty", 1'b1, q_gain.size() == 0);
        watch = 1'b0;
        ctrl = 8'h04;
        tgt = 8'h14;
        level = 8'd70;
        wait_gain(7'd10, 9000, k);
        cycles(1000);
        check_gain("hysteresis", 8'd10, {1'b0, gain});
        level = 8'd0;
        cycles(2900);
        check_gain("long_hold", 8'd10, {1'b0, gain});
        wait_gain(7'd20, 9000, k);
        cycles(1000);
        check_gain("gain_cap", 8'd20, {1'b0, gain});
        level = 8'd70;
        wait_gain(7'd10, 9000, k);
        ctrl = 8'h14;
        level = 8'd0;
        cycles(1400);
        check_gain("short_hold", 8'd10, {1'b0, gain});
        wait_gain(7'd11, 1500, k);
        level = 8'd70;
        wait_gain(7'd10, 2000, k);
        ssel = 8'hFF;
        ctrl = 8'h10;
        level = 8'd0;
        cycles(9000);
        check_gain("dual_min", 8'd10, {1'b0, gain});
        ssel = 8'h00;
        wait_gain(7'd20, 9000, k);
        $display("test gain done");
    endtask : gain_tests

    task automatic sample_tests;
        logic [15:0] p;
        filt = 2'h2;
        dc = 1'b1;
        wait_samples(3);
        repeat (2) q_smp.push_back(16'h7FFF);
        wait_samples(2);
        dc = 1'b0;
        wait_samples(3);
        repeat (2) q_smp.push_back(16'h8000);
        wait_samples(2);
        for (int f = 0; f < 2; f++) begin
            filt = 2'(f);
            wait_samples(2);
            dc = 1'b1;
            wait_samples(3);
            for (int i = 0; i < 2; i++) begin
                p = smp;
                wait_samples(1);
                check_bit("hpf_decay", 1'b1,
                          $signed(smp) < $signed(p));
            end
            dc = 1'b0;
        end
        $display("test samples done");
    endtask : sample_tests

    task automatic dac_tests;
        int   n;
        logic hs;
        n = 0;
        dvalid = 1'b1;
        dword = DAC_W'($urandom);
        for (int i = 0; i < 12; i++) begin
            // Ready is settled here and stands until the next edge
            hs = dready;
            @(negedge clk_in);
            if (hs) begin
                n++;
                dword = (n < 6) ? DAC_W'($urandom) : '0;
            end
        end
        dvalid = 1'b0;
        check_bit("fifo_depth", 1'b1, n inside {[8:9]});
        check_bit("full_refuse", 1'b0, dready);
        cycles(9 * 2600);
        check_bit("drained_ready", 1'b1, dready);
        check_bit("dac_zero", 1'b1, dlev === 4'h0);
        dvalid = 1'b1;
        dword = 20'h7_FFFF;
        cycles(1);
        dvalid = 1'b0;
        cycles(2600);
        check_bit("dac_full_scale", 1'b1, dlev === 4'h7);
        $display("test dac done");
    endtask : dac_tests

    initial begin
        void'($urandom(93));
        rst_in = 1'b1;
        ctrl = 8'h00;
        fsel = 8'h00;
        ssel = 8'h00;
        tgt = 8'h00;
        filt = 2'h0;
        level = 8'd0;
        dc = 1'b0;
        dword = '0;
        dvalid = 1'b0;
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        cycles(2);
        check_gain("reset_gain", 8'h00, {1'b0, gain});
        check_bit("reset_ready", 1'b1, dready);
        $display("test reset done");
        fork
            gain_tests();
            sample_tests();
            dac_tests();
        join
        report_and_stop();
    end

    initial begin
        // Longest test runs about 60000 cycles
        #900_000;
        num_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule : testbench
